// File: imu_pkg.sv
// Package for the iterative multiply unit: encodings, widths, carriers
package imu_pkg;

  // ------------------------------------------------------------------
  // Instruction field positions
  // ------------------------------------------------------------------
  localparam int COND_HI       = 31;
  localparam int COND_LO       = 28;
  localparam int SIGNED_BIT    = 22;
  localparam int ACCUM_BIT     = 21;
  localparam int SETFLAG_BIT   = 20;
  localparam int LONG_BIT      = 23;

  // ------------------------------------------------------------------
  // Datapath widths and array-cycle limits
  // ------------------------------------------------------------------
  localparam int WORD_W        = 32;
  localparam int SLICE_W       = 8;
  localparam int MAX_SLICES    = 4;
  localparam int CNT_W         = 3;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
  localparam logic [CNT_W-1:0] CNT_TWO = 3'h2;
  localparam logic [CNT_W-1:0] CNT_THR = 3'h3;
  localparam logic [CNT_W-1:0] CNT_FOU = 3'h4;

  // ------------------------------------------------------------------
  // Operation kinds
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_SHORT_PRODUCT,
    OP_SHORT_PRODUCT_ACCUM,
    OP_UNSIGNED_WIDE_PRODUCT,
    OP_UNSIGNED_WIDE_PRODUCT_ACCUM,
    OP_SIGNED_WIDE_PRODUCT,
    OP_SIGNED_WIDE_PRODUCT_ACCUM
  } imu_op_t;

  // ------------------------------------------------------------------
  // Issue request and result carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] instr;
    logic [31:0] multiplicand;
    logic [31:0] multiplier;
    logic [31:0] addend_lo;
    logic [31:0] addend_hi;
  } imu_req_t;

  typedef struct packed {
    logic [31:0] result_lo;
    logic [31:0] result_hi;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_flags;
    logic [3:0]  nzcv;
  } imu_res_t;

  // Flag positions in the nzcv nibble
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;

endpackage : imu_pkg

// File: imu_cond_eval.sv
// Condition-field evaluator against the current status word flags
module imu_cond_eval (
  // Condition and flags
  input  wire logic [3:0] i_cond,
  input  wire logic [3:0] i_nzcv,
  // Verdict
  output logic            o_pass
);

  logic n;
  logic z;
  logic c;
  logic v;

  // Flag split
  assign n = i_nzcv[imu_pkg::FLAG_N];
  assign z = i_nzcv[imu_pkg::FLAG_Z];
  assign c = i_nzcv[imu_pkg::FLAG_C];
  assign v = i_nzcv[imu_pkg::FLAG_V];

  // Standard sixteen-way condition table; code 0xe always passes, the last code 0xf never does
  always_comb begin
    case (i_cond)
      4'h0:    o_pass = z;
      4'h1:    o_pass = !z;
      4'h2:    o_pass = c;
      4'h3:    o_pass = !c;
      4'h4:    o_pass = n;
      4'h5:    o_pass = !n;
      4'h6:    o_pass = v;
      4'h7:    o_pass = !v;
      4'h8:    o_pass = c && !z;
      4'h9:    o_pass = !c || z;
      4'ha:    o_pass = (n == v);
      4'hb:    o_pass = (n != v);
      4'hc:    o_pass = !z && (n == v);
      4'hd:    o_pass = z || (n != v);
      4'he:    o_pass = 1'b1;
      default: o_pass = 1'b0;
    endcase
  end

endmodule : imu_cond_eval

// File: imu_core.sv
// Iterative 32x8 multiply unit with short and wide forms
module imu_core (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // Issue from decoder
  input  wire logic              i_issue,
  input  wire imu_pkg::imu_req_t i_req,
  input  wire logic [3:0]        i_nzcv,
  // Pipeline control
  output logic                   o_busy,
  output logic                   o_stall,
  // Write-back to register file and status word
  output logic                   o_done,
  output imu_pkg::imu_res_t      o_res
);

  // ------------------------------------------------------------------
  // Cycle plan
  // ------------------------------------------------------------------
  // Issue edge: operands, kind and flags captured, busy rises
  // Array state: one eight-bit multiplier slice per cycle, m cycles
  // Extra state: one wait per accumulate, one more for the wide form
  // Write state: the sequential cycle, accumulator already settled
  // Next cycle: done and write strobes pulse together once
  //
  // Extra cycles after the array, by form:
  //   short product           0
  //   short accumulate        1
  //   wide product            1
  //   wide accumulate         2
  //
  // Example, short product, m of one, no accumulate:
  //   cycle 0  issue seen, stall high, start taken at its closing edge
  //   cycle 1  array state, busy high
  //   cycle 2  write state, busy high
  //   cycle 3  done, low-word strobe, result valid, busy low
  //
  // Busy spans m plus extra plus one cycles; a new issue may be taken
  // in the cycle in which done is high.
  //
  // Flags: N and Z from the result, C and V from the issue-time word;
  // the wide forms may leave C and V as anything, the short V is kept.
  //
  // Limitations:
  // - Low slice first, shifted down: the early exit is exact only when
  //   all bits above the last slice repeat the sign or are zero.
  // - Short forms run the signed path: their low word is the same for
  //   either reading, and the sign-run early exit stays exact.
  // - The multiplicand is extended once at issue and shifted left per
  //   slice, so no slice needs an adder wider than 64 bits.
  // - Carry keeps its issue value; it may be anything, and keeping it
  //   saves a mux on the flag path.
  // - Conditions see the flags present at issue; flags written by the
  //   previous operation land only at the edge that ends its done cycle.
  // - Condition code 0xf never passes, so such issues are dropped.
  // - Operand registers are not checked; the issuer keeps them legal.
  // - Reset is synchronous and clears state, accumulator and outputs.

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------

  // Array cycles from multiplier top bits; sign runs count only if signed
  function automatic logic [imu_pkg::CNT_W-1:0] slices(input logic [31:0] mul,
                                                      input logic sgn);
    logic f8;
    logic f16;
    logic f24;
    f8  = (mul[31:8]  == '0) || (sgn && (mul[31:8]  == '1));
    f16 = (mul[31:16] == '0) || (sgn && (mul[31:16] == '1));
    f24 = (mul[31:24] == '0) || (sgn && (mul[31:24] == '1));
    if (f8)
      slices = imu_pkg::CNT_ONE;
    else if (f16)
      slices = imu_pkg::CNT_TWO;
    else if (f24)
      slices = imu_pkg::CNT_THR;
    else
      slices = imu_pkg::CNT_FOU;
  endfunction : slices

  // Sign or zero extension of a 32-bit operand to 64 bits
  function automatic logic [63:0] ext64(input logic [31:0] v, input logic sgn);
    ext64 = {{32{sgn & v[31]}}, v};
  endfunction : ext64

  // ------------------------------------------------------------------
  // Decode of the issued instruction
  // ------------------------------------------------------------------
  typedef enum {ST_IDLE, ST_ARRAY, ST_EXTRA, ST_WRITE} imu_state_t;

  logic       is_wide;
  logic       is_signed;
  logic       is_accum;
  logic       set_flags;
  logic       cond_pass;
  logic       mul_signed;
  logic       start;
  logic [imu_pkg::CNT_W-1:0] m_cnt;
  logic [imu_pkg::CNT_W-1:0] extra_cnt;

  // Wide form flagged by bit 23 of the multiply encodings
  assign is_wide   = i_req.instr[imu_pkg::LONG_BIT];
  // Signedness only meaningful for wide form; short low bits agree anyway
  assign is_signed = is_wide & i_req.instr[imu_pkg::SIGNED_BIT];
  assign is_accum  = i_req.instr[imu_pkg::ACCUM_BIT];
  assign set_flags = i_req.instr[imu_pkg::SETFLAG_BIT];
  // Short forms run the signed slice path; their low word is the same
  assign mul_signed = is_signed | !is_wide;
  // Short form counts sign runs too, as its table allows zeros or ones
  assign m_cnt     = slices(i_req.multiplier, mul_signed);
  // Internal cycles beyond the array: short 0/1, wide 1/2
  assign extra_cnt = imu_pkg::CNT_W'({1'b0, is_wide} + {1'b0, is_accum});

  imu_cond_eval u_cond (
    .i_cond (i_req.instr[imu_pkg::COND_HI:imu_pkg::COND_LO]),
    .i_nzcv (i_nzcv),
    .o_pass (cond_pass)
  );

  // Failed conditions never start the engine, so nothing is written
  assign start = i_issue && !o_busy && cond_pass;

  // ------------------------------------------------------------------
  // Iteration state
  // ------------------------------------------------------------------
  imu_state_t state_r;
  imu_state_t state_nxt;
  logic [63:0] acc_r;
  logic [63:0] acc_nxt;
  logic [63:0] mcand_r;
  logic [63:0] mcand_nxt;
  logic [31:0] mplier_r;
  logic [31:0] mplier_nxt;
  logic [imu_pkg::CNT_W-1:0] cnt_r;
  logic [imu_pkg::CNT_W-1:0] cnt_nxt;
  logic [imu_pkg::CNT_W-1:0] extra_r;
  logic [imu_pkg::CNT_W-1:0] extra_nxt;
  logic wide_r;
  logic signed_r;
  logic flags_r;
  logic [3:0] nzcv_in_r;
  logic [63:0] slice_prod;
  logic [63:0] final_val;
  logic        last_slice;

  // Eight multiplier bits times the extended multiplicand per array cycle.
  // The last slice of a signed operand carries negative weight.
  assign last_slice = (cnt_r == imu_pkg::CNT_ONE);
  assign slice_prod = (signed_r && last_slice) ?
                      64'(mcand_r * 64'($signed(mplier_r[31:0]))) :
                      64'(mcand_r * 64'(mplier_r[imu_pkg::SLICE_W-1:0]));

  // The accumulator result; short form keeps only the low word
  assign final_val = acc_r;

  // Next-state logic
  always_comb begin
    state_nxt  = state_r;
    acc_nxt    = acc_r;
    mcand_nxt  = mcand_r;
    mplier_nxt = mplier_r;
    cnt_nxt    = cnt_r;
    extra_nxt  = extra_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          // Accumulate preloads the addend pair; short uses low only
          if (is_accum)
            acc_nxt = is_wide ? {i_req.addend_hi, i_req.addend_lo}
                              : {32'h0, i_req.addend_lo};
          else
            acc_nxt = 64'h0;
          mcand_nxt  = ext64(i_req.multiplicand, is_signed);
          mplier_nxt = i_req.multiplier;
          cnt_nxt    = m_cnt;
          extra_nxt  = extra_cnt;
          state_nxt  = ST_ARRAY;
        end
      end
      ST_ARRAY: begin
        acc_nxt    = acc_r + slice_prod;
        mcand_nxt  = mcand_r << imu_pkg::SLICE_W;
        // Arithmetic shift keeps the remaining slice sign-correct
        mplier_nxt = signed_r ? 32'($signed(mplier_r) >>> imu_pkg::SLICE_W)
                              : (mplier_r >> imu_pkg::SLICE_W);
        cnt_nxt    = cnt_r - imu_pkg::CNT_ONE;
        if (last_slice)
          state_nxt = (extra_r == '0) ? ST_WRITE : ST_EXTRA;
      end
      ST_EXTRA: begin
        // Accumulate and high-word cycles, modelled as internal waits
        extra_nxt = extra_r - imu_pkg::CNT_ONE;
        if (extra_r == imu_pkg::CNT_ONE)
          state_nxt = ST_WRITE;
      end
      ST_WRITE: state_nxt = ST_IDLE; // Sequential write-back cycle
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r  <= ST_IDLE;
      acc_r    <= 64'h0;
      mcand_r  <= 64'h0;
      mplier_r <= 32'h0;
      cnt_r    <= '0;
      extra_r  <= '0;
    end else begin
      state_r  <= state_nxt;
      acc_r    <= acc_nxt;
      mcand_r  <= mcand_nxt;
      mplier_r <= mplier_nxt;
      cnt_r    <= cnt_nxt;
      extra_r  <= extra_nxt;
    end
  end

  // Operation attributes captured at issue
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wide_r    <= 1'b0;
      signed_r  <= 1'b0;
      flags_r   <= 1'b0;
      nzcv_in_r <= 4'h0;
    end else if (start) begin
      wide_r    <= is_wide;
      signed_r  <= mul_signed;
      flags_r   <= set_flags;
      nzcv_in_r <= i_nzcv;
    end
  end

  // ------------------------------------------------------------------
  // Write-back
  // ------------------------------------------------------------------
  logic [3:0] nzcv_new;
  logic       neg;
  logic       zero;
  logic       in_write;
  logic       wr_hi_nxt;
  logic       wr_flags_nxt;
  logic [31:0] hi_nxt;

  assign neg  = wide_r ? final_val[63] : final_val[31];
  assign zero = wide_r ? (final_val == 64'h0) : (final_val[31:0] == 32'h0);
  // Carry is don't-care: old value kept; V kept for short, free for wide
  assign nzcv_new = {neg, zero, nzcv_in_r[imu_pkg::FLAG_C],
                     nzcv_in_r[imu_pkg::FLAG_V]};

  // Write state decode shared by strobes and data
  assign in_write     = (state_r == ST_WRITE);
  assign wr_hi_nxt    = in_write && wide_r;
  assign wr_flags_nxt = in_write && flags_r;
  // Short forms never carry a high word to the register file
  assign hi_nxt       = wide_r ? final_val[63:32] : 32'h0;

  // Registered result, pulsed for one cycle after the write state
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_done <= 1'b0;
      o_res  <= '0;
    end else begin
      o_done         <= in_write;
      o_res.wr_lo    <= in_write;
      o_res.wr_hi    <= wr_hi_nxt;
      o_res.wr_flags <= wr_flags_nxt;
      // Data holds between completions; only the strobes pulse
      if (in_write) begin
        o_res.result_lo <= final_val[31:0];
        o_res.result_hi <= hi_nxt;
        o_res.nzcv      <= nzcv_new;
      end
    end
  end

  // Issuer is held while any internal cycle remains
  assign o_busy  = (state_r != ST_IDLE);
  assign o_stall = o_busy || start;

endmodule : imu_core

// File: imu_core_properties.sv
// Checker of timing, pairing and flag relations at the multiply unit ports
module imu_core_properties (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // Issue side
  input  wire logic              i_issue,
  input  wire imu_pkg::imu_req_t i_req,
  input  wire logic [3:0]        i_nzcv,
  // Result side
  input  wire logic              o_busy,
  input  wire logic              o_stall,
  input  wire logic              o_done,
  input  wire imu_pkg::imu_res_t o_res
);
  // ------------------------------------------------------------------
  // Helper logic: kind and expected length of the running operation
  // ------------------------------------------------------------------
  logic       wide_r, flag_r, v_r;
  logic [3:0] cnt_r, exp_r, exp_nxt;
  logic       start;

  // Array cycles; zo limits the early exit to all-zero upper bits
  function automatic int mcnt(input logic [31:0] v, input bit zo);
    for (int k = 1; k < 4; k++)
      if ((v >> (8 * k)) == 0 || (!zo && ($signed(v) >>> (8 * k)) == -1)) return k;
    return 4;
  endfunction : mcnt

  // Accepted start: stall raised while not yet busy
  assign start   = i_issue && !o_busy && o_stall;
  assign exp_nxt = 4'(mcnt(i_req.multiplier, i_req.instr[23] && !i_req.instr[22])
                   + i_req.instr[23] + i_req.instr[21] + 2);

  // Latch operation kind at start, count cycles up to completion
  always_ff @(posedge i_clk) begin
    if (start) begin
      wide_r <= i_req.instr[imu_pkg::LONG_BIT];
      flag_r <= i_req.instr[imu_pkg::SETFLAG_BIT];
      v_r    <= i_nzcv[imu_pkg::FLAG_V];
      exp_r  <= exp_nxt;
      cnt_r  <= 4'h1; // Cycle after the issue cycle counts as the first
    end else begin
      cnt_r  <= cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  sequence s_start;
    i_issue && !o_busy && o_stall;
  endsequence
  sequence s_hold;
    (o_busy && o_stall && !o_done) [*2];
  endsequence

  property p_cond_skip;
    i_issue && !o_busy && i_req.instr[31:28] == 4'h0 && !i_nzcv[2] |=> !o_busy && !o_done;
  endproperty
  property p_short_pair;
    o_done && !wide_r |-> o_res.wr_lo && !o_res.wr_hi && o_res.result_hi == 32'h0;
  endproperty
  property p_short_flags;
    o_done && !wide_r && flag_r |-> o_res.nzcv[3] == o_res.result_lo[31]
      && o_res.nzcv[2] == (o_res.result_lo == 32'h0);
  endproperty
  property p_short_v;
    o_done && !wide_r && flag_r |-> o_res.nzcv[0] == v_r;
  endproperty
  property p_latency;
    o_done |-> cnt_r == exp_r;
  endproperty
  property p_wide_pair;
    o_done && wide_r |-> o_res.wr_lo && o_res.wr_hi;
  endproperty
  property p_wide_flags;
    o_done && wide_r && flag_r |-> o_res.nzcv[3] == o_res.result_hi[31]
      && o_res.nzcv[2] == ({o_res.result_hi, o_res.result_lo} == 64'h0);
  endproperty
  property p_flag_en;
    o_done |-> o_res.wr_flags == flag_r;
  endproperty
  property p_stall;
    s_start |=> s_hold;
  endproperty
  property p_finish;
    s_start |-> ##[3:8] o_done;
  endproperty
  property p_write_end;
    o_res.wr_lo || o_res.wr_hi || o_res.wr_flags |-> o_done;
  endproperty

  a_cond_skip: assert property (p_cond_skip) else $error("failed condition still ran");
  a_short_pair: assert property (p_short_pair) else $error("short result pairing");
  a_short_flags: assert property (p_short_flags) else $error("short N or Z flag");
  a_short_v: assert property (p_short_v) else $error("short V flag not kept");
  a_latency: assert property (p_latency) else $error("cycle count off");
  a_wide_pair: assert property (p_wide_pair) else $error("wide result halves");
  a_wide_flags: assert property (p_wide_flags) else $error("wide N or Z flag");
  a_flag_en: assert property (p_flag_en) else $error("flag write enable");
  a_stall: assert property (p_stall) else $error("stall dropped early");
  a_finish: assert property (p_finish) else $error("no completion");
  a_write_end: assert property (p_write_end) else $error("write outside completion");
endmodule : imu_core_properties

bind imu_core imu_core_properties chk_u (.i_clk(i_clk), .i_reset(i_reset), .i_issue(i_issue),
  .i_req(i_req), .i_nzcv(i_nzcv), .o_busy(o_busy), .o_stall(o_stall), .o_done(o_done),
  .o_res(o_res));

// File: imu_issuer.sv
// Issuing-side model: holds a request until taken and keeps the status flags
module imu_issuer (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // Bench side
  input  wire logic              i_go,
  input  wire imu_pkg::imu_req_t i_req_in,
  // Unit side
  input  wire logic              i_busy,
  input  wire imu_pkg::imu_res_t i_res,
  output logic                   o_issue,
  output imu_pkg::imu_req_t      o_req,
  output logic [3:0]             o_nzcv
);
  timeunit 1ns;
  timeprecision 100ps;

  // Request held until an edge with the unit idle; released lines toggle
  // Operands stand for distinct non-counter registers
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_issue <= 1'b0;
      o_req   <= '0;
      o_nzcv  <= 4'h1;
    end else begin
      if (!o_issue && i_go) begin
        o_issue <= 1'b1;
        o_req   <= i_req_in;
      end else if (o_issue && !i_busy) begin
        o_issue <= 1'b0;
        o_req   <= ~o_req;
      end
      if (i_res.wr_flags) o_nzcv <= i_res.nzcv;
    end
  end
endmodule : imu_issuer

// File: iterative_multiply_unit_bench.sv
// Self-checking bench for the iterative multiply unit
module iterative_multiply_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic              i_clk, i_reset, go, issue, busy, stall, done;
  logic [3:0]        nzcv;
  imu_pkg::imu_req_t req_in, req;
  imu_pkg::imu_res_t res;
  int                error_cnt, checks;

  imu_core dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_issue(issue), .i_req(req),
    .i_nzcv(nzcv), .o_busy(busy), .o_stall(stall), .o_done(done), .o_res(res));
  imu_issuer issuer_u (.i_clk(i_clk), .i_reset(i_reset), .i_go(go), .i_req_in(req_in),
    .i_busy(busy), .i_res(res), .o_issue(issue), .o_req(req), .o_nzcv(nzcv));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Expected array cycles; zo allows only all-zero upper bits
  function automatic int mcnt(input logic [31:0] v, input bit zo);
    for (int k = 1; k < 4; k++)
      if ((v >> (8 * k)) == 0 || (!zo && ($signed(v) >>> (8 * k)) == -1)) return k;
    return 4;
  endfunction : mcnt

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // One operation; ok low means the condition fails and nothing may finish
  task automatic run(input logic [31:0] ins, mc, mp, alo, ahi, elo, ehi,
                     input logic [3:0] enz, input bit ok);
    int         n;
    int         en;
    logic [3:0] mk;
    en = mcnt(mp, ins[23] && !ins[22]) + ins[23] + ins[21] + 2;
    mk = ins[23] ? 4'hc : 4'hd;
    @(negedge i_clk);
    go = 1'b1;
    req_in = '{ins, mc, mp, alo, ahi};
    @(negedge i_clk);
    go = 1'b0;
    chk(64'(stall), 64'(ok));
    @(negedge i_clk);
    n = 1;
    // Bounded wait; 12 exceeds the longest legal operation
    while (done !== 1'b1 && n < 12) begin
      @(negedge i_clk);
      n++;
    end
    chk(64'(n), 64'(ok ? en : 12));
    if (ok) begin
      chk({res.result_hi, res.result_lo}, {ehi, elo});
      chk(64'({res.wr_lo, res.wr_hi}), 64'({1'b1, ins[23]}));
      chk(64'(res.wr_flags), 64'(ins[20]));
    end
    if (ins[20]) chk(64'((ok ? res.nzcv : nzcv) & mk), 64'(enz & mk));
    $display("test %h finished", ins);
  endtask : run

  // Watchdog, far beyond the fewer than a hundred cycles the tests need
  initial begin
    #10000;
    error_cnt++;
    stop_test();
  end

  initial begin
    i_reset = 1'b1;
    go = 1'b0;
    req_in = '0;
    error_cnt = 0;
    checks = 0;
    repeat (16) @(negedge i_clk);
    i_reset = 1'b0;
    run(32'he0100000, 32'hfffffff6, 32'h14, 32'h0, 32'h0, 32'hffffff38, 32'h0, 4'h9, 1'b1);
    run(32'he0200000, 32'h3, 32'h10000, 32'hfffffffd, 32'h0, 32'h2fffd, 32'h0, 4'h0, 1'b1);
    run(32'he0000000, 32'h2, 32'hffffff80, 32'h0, 32'h0, 32'hffffff00, 32'h0, 4'h0, 1'b1);
    run(32'he0100000, 32'h0, 32'h12345678, 32'h0, 32'h0, 32'h0, 32'h0, 4'h5, 1'b1);
    run(32'h00100000, 32'h5, 32'h5, 32'h0, 32'h0, 32'h19, 32'h0, 4'h1, 1'b1);
    run(32'h00100000, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 4'h1, 1'b0);
    run(32'he0800000, 32'hffffffff, 32'hffffff80, 32'h0, 32'h0, 32'h80, 32'hffffff7f, 4'h0,
        1'b1);
    run(32'he0d00000, 32'hffffffff, 32'hffffff80, 32'h0, 32'h0, 32'h80, 32'h0, 4'h0,
        1'b1);
    run(32'he0f00000, 32'hfffffffe, 32'h100, 32'h1ff, 32'h0, 32'hffffffff, 32'hffffffff, 4'h8,
        1'b1);
    run(32'he0b00000, 32'h1, 32'h1, 32'hffffffff, 32'hffffffff, 32'h0, 32'h0, 4'h4,
        1'b1);
    stop_test();
  end
endmodule : iterative_multiply_unit_bench
